// ---- kwu_keys.sv ----
// keypad switch model standing on the pins of the wake unit
`timescale 1ns/10ps
module kwu_keys (
  input wire kwu_pkg::kwu_byte_t i_down,
  input wire kwu_pkg::kwu_pol_t i_pol,
  output kwu_pkg::kwu_byte_t o_pin
);
  import kwu_pkg::*;
  // a released key rests on the pull opposite to its asserted level
  assign o_pin = ~(i_down ^ {i_pol, 4'h0});
endmodule

// ---- kwu_map.svh ----
// register offsets, field positions and reset values of the keypad wake unit
`ifndef KWU_MAP_SVH
`define KWU_MAP_SVH
`define KWU_AW 12
`define KWU_OFF_CTRL 12'h000
`define KWU_OFF_SEL 12'h004
`define KWU_OFF_EVT 12'h008
`define KWU_OFF_MSK 12'h00C
`define KWU_OFF_PIN 12'h010
`define KWU_CTRL_MODE 0
`define KWU_CTRL_IE 1
`define KWU_CTRL_ACK 2
`define KWU_CTRL_FLAG 3
`define KWU_CTRL_POL_LO 4
`define KWU_EVT_EDGE 0
`define KWU_EVT_REFUSED 1
`define KWU_RST_POL 4'h0
`define KWU_RST_SEL 8'h00
`define KWU_RST_MSK 2'h0
`endif

// ---- kwu_pin_detect.sv ----
// per-pin polarity and synchronous edge detection of the keypad wake unit
`timescale 1ns/10ps
module kwu_pin_detect #(
  parameter int N = 8,
  parameter int NFIX = 4
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  kwu_pin_if.det pins
);
  import kwu_pkg::*;

  logic [N-1:0] seen_reg;

  genvar g;
  generate
    for (g = 0; g < N; g = g + 1) begin : g_pin
      if (g < NFIX) begin : g_fix
        assign pins.asserted[g] = ~pins.sample[g];
      end else begin : g_pol
        // polarity bit 1 means high is asserted
        assign pins.asserted[g] =
          pins.sample[g] ^ ~pins.pol[g-NFIX];
      end
      // one bus cycle deasserted, the next asserted
      assign pins.edge_hit[g] = seen_reg[g] & pins.asserted[g]
        & pins.sel[g] & ~pins.hold_off;
    end
  endgenerate

  // a pin arms only after it was seen deasserted while selected
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      seen_reg <= '0;
    end else begin
      seen_reg <= pins.sel & ~pins.asserted;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  a_edge_needs_seen: assert property (
    (pins.edge_hit & ~$past(pins.sel & ~pins.asserted)) == '0)
    else $error("edge without a prior deasserted sample");
  a_fall_edge: assert property (
    pins.sel[0] && pins.sample[0] && !pins.hold_off ##1
    (pins.sel[0] && !pins.sample[0] && !pins.hold_off)
    |-> pins.edge_hit[0])
    else $error("falling edge on pin 0 missed");
  a_rise_edge: assert property (
    pins.sel[N-1] && pins.pol[N-NFIX-1] && !pins.sample[N-1]
    && !pins.hold_off ##1 (pins.sel[N-1] && pins.pol[N-NFIX-1]
    && pins.sample[N-1] && !pins.hold_off) |-> pins.edge_hit[N-1])
    else $error("rising edge on top pin missed");
  a_unsel_silent: assert property (
    (pins.edge_hit & ~pins.sel) == '0)
    else $error("edge reported on an unselected pin");
endmodule

// ---- kwu_pin_if.sv ----
// bundle between the register side and the per-pin edge detector
`timescale 1ns/10ps
interface kwu_pin_if;
  import kwu_pkg::*;
  kwu_byte_t sample;
  kwu_byte_t sel;
  kwu_pol_t pol;
  logic hold_off;
  kwu_byte_t asserted;
  kwu_byte_t edge_hit;
  modport ctl (output sample, sel, pol, hold_off,
    input asserted, edge_hit);
  modport det (input sample, sel, pol, hold_off,
    output asserted, edge_hit);
endinterface

// ---- kwu_pkg.sv ----
// types shared by the keypad wake unit
package kwu_pkg;
  typedef logic [7:0] kwu_byte_t;
  typedef logic [3:0] kwu_pol_t;
  typedef logic [1:0] kwu_evt_t;
  typedef enum logic {KWU_EDGE_ONLY, KWU_EDGE_LEVEL} kwu_mode_t;
endpackage

// ---- kwu_top.sv ----
// keypad wake unit: APB registers, event flag, interrupt and wake
//
// Our own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps
`include "kwu_map.svh"
// Operation
// - a set select bit ties its pin to detection; clear leaves it GPIO
// - edges found synchronously; a pin must be seen deasserted first
// - falling edge is a 1 sample then a 0 sample next cycle
// - rising edge is a 0 sample then a 1 sample next cycle
// - any qualifying edge on a selected pin sets the event flag
// - level mode edge: pins assert while other selected pins stay idle
// - level mode holds the flag set while any selected pin is asserted
// - in edge-only mode an acknowledge write clears the flag unless an edge arrives in the same cycle
// - with interrupt enable set, request interrupt while flag is 1
// - in stop mode edges are bypassed; pins wake asynchronously by level
// - pins 3..0 fall/low; pins 7..4 follow their polarity bit
// - the acknowledge bit is write-only and always reads 0
// - a selected pin is forced to input whatever its GPIO direction
// - interrupt enable clear blocks flag requests (unmasked events still request), the flag still sets
module kwu_top (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire kwu_pkg::kwu_byte_t i_pin,
  input wire kwu_pkg::kwu_byte_t i_gpio_dir,
  input wire logic i_stop,
  output kwu_pkg::kwu_byte_t o_pin_oe,
  output logic o_irq,
  output logic o_wake
);
  import kwu_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // reset release

  logic rst_meta;
  logic rst_sync;
  logic rst_n;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  assign rst_n = rst_sync;

  ////////////////////////////////////////////////////////////////////////
  // control state

  kwu_byte_t sel_reg;
  kwu_pol_t pol_reg;
  logic ie_reg;
  kwu_mode_t mode_reg;
  logic flag_reg;
  logic flag_next;
  kwu_evt_t evt_reg;
  kwu_evt_t msk_reg;
  kwu_evt_t evt_set;
  kwu_evt_t evt_clr;
  logic irq_next;

  ////////////////////////////////////////////////////////////////////////
  // pin detection

  kwu_pin_if pins ();

  assign pins.sample = i_pin;
  assign pins.sel = sel_reg;
  assign pins.pol = pol_reg;
  assign pins.hold_off = i_stop;

  kwu_pin_detect #(
    .N(8),
    .NFIX(4)
  ) u_detect (
    .i_clk(i_clk),
    .i_rst_n(rst_n),
    .pins(pins)
  );

  kwu_byte_t act_now;
  kwu_byte_t act_prev;
  logic any_act;
  logic edge_evt;

  assign act_now = pins.asserted & sel_reg;
  assign any_act = |act_now;

  // previous asserted map, used to tell a fresh press from a held key
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      act_prev <= 8'h00;
    end else begin
      act_prev <= act_now;
    end
  end

  // in level mode a press only counts if nothing else was still held
  always_comb begin
    if (mode_reg == KWU_EDGE_LEVEL) begin
      edge_evt = |pins.edge_hit && ((act_prev & sel_reg) == 8'h00);
    end else begin
      edge_evt = |pins.edge_hit;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // APB slave: zero wait states, answer in the access cycle

  logic setup;
  logic done;
  logic wr;
  logic ack_wr;
  logic hold;
  logic [31:0] rd_next;
  logic err_next;

  // an unmapped address answers with an error and writes nothing
  assign setup = i_psel & ~i_penable;
  assign done = i_psel & i_penable & o_pready;
  assign wr = done & i_pwrite & ~o_pslverr;
  assign ack_wr = wr && (i_paddr == `KWU_OFF_CTRL)
    && i_pwdata[`KWU_CTRL_ACK];

  always_comb begin
    rd_next = 32'h0000_0000;
    err_next = 1'b0;
    case (i_paddr)
      `KWU_OFF_CTRL: begin
        rd_next[7:4] = pol_reg;
        rd_next[`KWU_CTRL_FLAG] = flag_reg;
        rd_next[`KWU_CTRL_ACK] = 1'b0;
        rd_next[`KWU_CTRL_IE] = ie_reg;
        rd_next[`KWU_CTRL_MODE] = mode_reg;
      end
      `KWU_OFF_SEL: rd_next[7:0] = sel_reg;
      `KWU_OFF_EVT: rd_next[1:0] = evt_reg;
      `KWU_OFF_MSK: rd_next[1:0] = msk_reg;
      `KWU_OFF_PIN: rd_next[7:0] = i_pin;
      default: err_next = 1'b1;
    endcase
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_prdata <= 32'h0000_0000;
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= setup;
      if (setup) begin
        o_prdata <= i_pwrite ? 32'h0000_0000 : rd_next;
        o_pslverr <= err_next;
      end else if (done) begin
        o_pslverr <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_reg <= `KWU_RST_SEL;
      pol_reg <= `KWU_RST_POL;
      ie_reg <= 1'b0;
      mode_reg <= KWU_EDGE_ONLY;
      msk_reg <= `KWU_RST_MSK;
    end else if (wr) begin
      case (i_paddr)
        `KWU_OFF_CTRL: begin
          pol_reg <= i_pwdata[7:4];
          ie_reg <= i_pwdata[`KWU_CTRL_IE];
          mode_reg <= kwu_mode_t'(i_pwdata[`KWU_CTRL_MODE]);
        end
        `KWU_OFF_SEL: sel_reg <= i_pwdata[7:0];
        `KWU_OFF_MSK: msk_reg <= i_pwdata[1:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // event flag

  // a held key in level mode keeps the flag up; stop gates nothing here
  assign hold = (mode_reg == KWU_EDGE_LEVEL) && any_act;

  always_comb begin
    if (edge_evt || hold) begin
      flag_next = 1'b1;
    end else if (ack_wr) begin
      flag_next = 1'b0;
    end else begin
      flag_next = flag_reg;
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_reg <= 1'b0;
    end else begin
      flag_reg <= flag_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // sticky events, cleared by reading them; a new set beats the clear

  assign evt_set[`KWU_EVT_EDGE] = edge_evt;
  // an acknowledge refused by a held key is recorded for software
  assign evt_set[`KWU_EVT_REFUSED] = ack_wr & hold;
  // only bits that were returned are cleared
  assign evt_clr = (done && !i_pwrite && i_paddr == `KWU_OFF_EVT)
    ? o_prdata[1:0] : 2'h0;

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      evt_reg <= 2'h0;
    end else begin
      evt_reg <= (evt_reg & ~evt_clr) | evt_set;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  // the flag term of the request is built from flag_next, so it rises on the same
  // edge as the flag and drops on the same edge as the acknowledge
  assign irq_next = (ie_reg & flag_next)
    | (|(evt_reg & msk_reg));

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_irq <= 1'b0;
      o_pin_oe <= 8'h00;
    end else begin
      o_irq <= irq_next;
      o_pin_oe <= i_gpio_dir & ~sel_reg;
    end
  end

  // clocks are halted in stop, so wake must not wait for an edge;
  // this is the one output that is not registered
  assign o_wake = i_stop & any_act;

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!rst_n);

  a_edge_sets_flag: assert property (
    edge_evt |=> flag_reg)
    else $error("edge event did not set the flag");
  a_level_holds: assert property (
    (mode_reg == KWU_EDGE_LEVEL) && any_act && ack_wr |=> flag_reg)
    else $error("acknowledge cleared a held level flag");
  a_ack_clears: assert property (
    (mode_reg == KWU_EDGE_ONLY) && ack_wr && !edge_evt
    |=> !flag_reg)
    else $error("acknowledge failed to clear the flag");
  a_set_wins: assert property (
    edge_evt && ack_wr |=> flag_reg)
    else $error("edge lost against acknowledge");
  a_irq_follows: assert property (
    ie_reg && flag_next |=> o_irq)
    else $error("interrupt not requested while flag set");
  a_irq_cause: assert property (
    o_irq |-> $past(ie_reg && flag_next) || $past(|(evt_reg & msk_reg)))
    else $error("interrupt without enabled cause");
  a_level_first: assert property (
    (mode_reg == KWU_EDGE_LEVEL) && |(act_prev & sel_reg)
    |-> !edge_evt)
    else $error("level mode edge while another pin held");
  a_ack_reads_zero: assert property (
    setup && !i_pwrite && i_paddr == `KWU_OFF_CTRL
    |=> !o_prdata[`KWU_CTRL_ACK])
    else $error("acknowledge bit read back as one");
  a_forced_input: assert property (
    ##1 (o_pin_oe & $past(sel_reg)) == 8'h00)
    else $error("selected pin still driven");
  a_stop_bypass: assert property (
    i_stop |-> !edge_evt ##0 (o_wake == any_act))
    else $error("edge seen or wake wrong in stop");
  a_apb_answer: assert property (
    setup |=> o_pready ##1 !o_pready)
    else $error("pready not a single access cycle");

  ////////////////////////////////////////////////////////////////////////
  // further checks on the pin rules, events and bus errors

  a_fall_flag: assert property (
    (sel_reg[1] && i_pin[1] && !i_stop) ##1 (sel_reg[1] && !i_pin[1]
    && !i_stop && mode_reg == KWU_EDGE_ONLY) |=> flag_reg)
    else $error("falling edge on pin 1 left the flag clear");
  a_rise_flag: assert property (
    (sel_reg[7] && pol_reg[3] && !i_pin[7] && !i_stop) ##1
    (sel_reg[7] && pol_reg[3] && i_pin[7] && !i_stop
    && mode_reg == KWU_EDGE_ONLY) |=> flag_reg)
    else $error("rising edge on pin 7 left the flag clear");

  a_poll_flag: assert property (
    !ie_reg && edge_evt |=> flag_reg)
    else $error("flag did not set with interrupts disabled");
  a_irq_quiet: assert property (
    !ie_reg && ((evt_reg & msk_reg) == 2'h0) |=> !o_irq)
    else $error("interrupt requested while disabled");
  a_level_held: assert property (
    (mode_reg == KWU_EDGE_LEVEL) && any_act |=> flag_reg)
    else $error("flag dropped while a selected pin is held");
  a_oe_gpio: assert property (
    ##1 o_pin_oe == ($past(i_gpio_dir) & ~$past(sel_reg)))
    else $error("unselected pin lost its GPIO direction");

  a_evt_edge: assert property (
    edge_evt |=> evt_reg[`KWU_EVT_EDGE])
    else $error("edge event not recorded");
  a_evt_sticky: assert property (
    evt_reg[`KWU_EVT_EDGE] && !evt_clr[`KWU_EVT_EDGE]
    |=> evt_reg[`KWU_EVT_EDGE])
    else $error("edge record dropped without a read");

  a_err_no_write: assert property (
    done && o_pslverr |=> $stable(sel_reg) && $stable(pol_reg)
    && $stable(msk_reg))
    else $error("refused write changed a register");
  a_err_with_ready: assert property (
    o_pslverr |-> o_pready)
    else $error("bus error outside the access cycle");

  c_edge_irq: cover property (edge_evt && ie_reg ##1 o_irq);
  c_ack_refused: cover property (evt_set[`KWU_EVT_REFUSED]);
  c_set_vs_ack: cover property (edge_evt && ack_wr);
  c_stop_wake: cover property (i_stop && any_act);
  c_mask_irq: cover property (|(evt_reg & msk_reg) ##1 o_irq);
endmodule

// ---- tb_keypad_edge_level_interrupt.sv ----
// self-checking bench of the keypad wake unit
`timescale 1ns/10ps
`include "kwu_map.svh"
module tb_keypad_edge_level_interrupt;
  import kwu_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic stop = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic wake;
  kwu_byte_t pin;
  kwu_byte_t oe;
  kwu_byte_t gdir = 8'h00;
  kwu_byte_t down = 8'h00;
  kwu_pol_t pol = 4'h0;
  logic [31:0] seed = 32'hFDC94D73;
  logic [31:0] cw = 32'h0;
  logic [31:0] r;
  logic e;
  logic msk_m = 1'b0;
  int err_count = 0;
  int checks = 0;
  int k;

  always #10 clk = ~clk;

  kwu_top dut_u (.i_clk(clk), .i_rst_n(rst_n), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_pin(pin), .i_gpio_dir(gdir), .i_stop(stop), .o_pin_oe(oe),
    .o_irq(irq), .o_wake(wake));
  kwu_keys keys_u (.i_down(down), .i_pol(pol), .o_pin(pin));

  ////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] x,
    input logic [31:0] g);
    checks++;
    if (g !== x) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, x, g);
    end
  endtask

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  // model of the control word: written fields plus the flag
  function automatic logic [31:0] ce(input logic f);
    return cw | {28'h0, f, 3'h0};
  endfunction

  // one transfer; the access is held until pready is seen high at a
  // rising edge, the answer is taken at that edge, then released
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (pready !== 1'b1) begin
      err_count++;
      give_verdict();
    end
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk("prdata", x, r);
    chk("pslverr", 32'h0, {31'h0, e});
  endtask

  // press key b, expect flag f; lvl keeps it pressed over the ack
  task automatic hit(input int b, input logic f, input logic lvl);
    @(posedge clk);
    down[b] <= 1'b1;
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk("irq", {31'h0, f & (cw[1] | msk_m)}, {31'h0, irq});
    rd(`KWU_OFF_CTRL, ce(f));
    @(posedge clk);
    down[b] <= lvl;
    apb(1'b1, `KWU_OFF_CTRL, cw | 32'h4);
    rd(`KWU_OFF_CTRL, ce(lvl & f));
    down[b] <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(`KWU_OFF_CTRL, 32'h0);
    rd(`KWU_OFF_SEL, 32'h0);
    apb(1'b0, 12'h020, 32'h0);
    chk("pslverr", 32'h1, {31'h0, e});
    chk("prdata", 32'h0, r);
    cw = 32'h2;
    apb(1'b1, `KWU_OFF_CTRL, cw);
    for (k = 0; k < 4; k++) begin
      seed = xs(seed);
      gdir <= seed[15:8];
      apb(1'b1, `KWU_OFF_SEL, {24'h0, seed[7:0]});
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk("pin_oe", {24'h0, gdir & ~seed[7:0]}, {24'h0, oe});
      hit(seed[18:16], seed[seed[18:16]], 1'b0);
    end
    apb(1'b1, `KWU_OFF_SEL, 32'hFF);
    for (k = 0; k < 8; k++) hit(k, 1'b1, 1'b0);
    // polarity flips pin levels, so it is changed while nothing is selected
    apb(1'b1, `KWU_OFF_SEL, 32'h0);
    pol <= 4'hF;
    cw = 32'hF2;
    apb(1'b1, `KWU_OFF_CTRL, cw);
    apb(1'b1, `KWU_OFF_SEL, 32'hFF);
    for (k = 0; k < 8; k++) hit(k, 1'b1, 1'b0);
    cw = 32'hF0;
    apb(1'b1, `KWU_OFF_CTRL, cw);
    hit(5, 1'b1, 1'b0);
    cw = 32'hF3;
    apb(1'b1, `KWU_OFF_CTRL, cw);
    hit(1, 1'b1, 1'b1);
    apb(1'b1, `KWU_OFF_CTRL, cw | 32'h4);
    rd(`KWU_OFF_CTRL, ce(1'b0));
    rd(`KWU_OFF_EVT, 32'h3);
    rd(`KWU_OFF_EVT, 32'h0);
    cw = 32'hF0;
    apb(1'b1, `KWU_OFF_CTRL, cw);
    msk_m = 1'b1;
    apb(1'b1, `KWU_OFF_MSK, 32'h1);
    rd(`KWU_OFF_MSK, 32'h1);
    hit(2, 1'b1, 1'b0);
    rd(`KWU_OFF_EVT, 32'h1);
    @(posedge clk);
    @(negedge clk);
    chk("irq", 32'h0, {31'h0, irq});
    @(posedge clk);
    stop <= 1'b1;
    down[3] <= 1'b1;
    @(negedge clk);
    chk("wake", 32'h1, {31'h0, wake});
    @(posedge clk);
    down[3] <= 1'b0;
    @(negedge clk);
    chk("wake", 32'h0, {31'h0, wake});
    give_verdict();
  end
endmodule
